// ---- dc_valve_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef DC_VALVE_REGS_SVH
`define DC_VALVE_REGS_SVH

`define OFF_CTRL 8'h00
`define OFF_DELAY 8'h04
`define OFF_BOOST 8'h08
`define OFF_TRIP 8'h0C
`define OFF_STATUS 8'h10

`define CTRL_LATCH 0
`define CTRL_TWO_WIRE 1
`define CTRL_LOCAL 2
`define CTRL_BOOST_OPEN 3
`define CTRL_ADJUST 4

`define RST_CTRL 5'h00
`define RST_DELAY 16'h0000
`define RST_BOOST 31'h00646464
`define RST_TRIP 8'h78

`define CLK_NS 20
`define TICK_NS 100000000
`define TICK_MS 100
`define HOLD_MS 1000
`define MAX_DELAY_MS 12000
`define HOLD_TICKS 7'h0A
`define MAX_TICKS 7'h78
`define PCT_BASE 8'h64
`define PCT_MAX 8'hC8
`define TRIP_FIXED 8'h78

`endif

// ---- dc_valve_pkg.sv ----
// Types shared by the valve actuator controller
package dc_valve_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WAIT_OPEN = 6'h02,
        ST_WAIT_CLOSE = 6'h04,
        ST_RUN_OPEN = 6'h08,
        ST_RUN_CLOSE = 6'h10,
        ST_HOLD = 6'h20
    } state_t;

    typedef enum logic [1:0] {
        PWR_IDLE = 2'h0,
        PWR_OPEN = 2'h1,
        PWR_CLOSE = 2'h2
    } pwrup_t;

endpackage

// ---- dc_valve_actuator_controller.sv ----
// Open/close DC valve actuator controller with APB configuration
`timescale 1ns/1ns
`include "dc_valve_regs.svh"

module dc_valve_actuator_controller
    import dc_valve_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Commands, pushbuttons and limit switches (limit high = closed, ok)
    input wire logic open_cmd,
    input wire logic close_cmd,
    input wire logic open_button,
    input wire logic close_button,
    input wire logic open_limit_ok,
    input wire logic close_limit_ok,
    // Trip sensing, external trip reset (low resets), power-up option
    input wire logic [7:0] motor_current,
    input wire logic trip_reset_n,
    input wire logic [1:0] powerup_select,
    // Motor and indicators
    output logic drive_open,
    output logic drive_close,
    output logic brake_on,
    output logic [7:0] torque_pct,
    output logic red_led,
    output logic green_led,
    output logic trip_led,
    output logic trip_alarm
);

    function automatic logic [6:0] lim_ticks(input logic [6:0] v);
        lim_ticks = (v > `MAX_TICKS) ? `MAX_TICKS : v;
    endfunction

    function automatic logic [7:0] clamp_pct(input logic [7:0] p);
        if (p < `PCT_BASE)
            clamp_pct = `PCT_BASE;
        else if (p > `PCT_MAX)
            clamp_pct = `PCT_MAX;
        else
            clamp_pct = p;
    endfunction

    // Configuration registers
    logic [4:0] ctrl;
    logic [15:0] delay_cfg;
    logic [30:0] boost_cfg;
    logic [7:0] trip_level;

    // Fixed tick, one pulse per 100 ms
    logic [22:0] tick_cnt;
    logic tick;
    assign tick = (tick_cnt == 23'(TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tick_cnt <= 23'h000000;
        else if (tick)
            tick_cnt <= 23'h000000;
        else
            tick_cnt <= tick_cnt + 23'h000001;
    end

    // Input conditioning: two flops, then agree on two tick samples
    logic [5:0] raw_in;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] samp;
    logic [5:0] deb;
    logic [5:0] agree;
    logic rst_s1;
    logic rst_s2;
    assign raw_in = {close_limit_ok, open_limit_ok, close_button,
                     open_button, close_cmd, open_cmd};
    assign agree = ~(sync2 ^ samp);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            samp <= 6'h00;
            deb <= 6'h00;
            rst_s1 <= 1'b1;
            rst_s2 <= 1'b1;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            rst_s1 <= trip_reset_n;
            rst_s2 <= rst_s1;
            if (tick) begin
                samp <= sync2;
                deb <= (agree & sync2) | (~agree & deb);
            end
        end
    end

    logic cmd_o;
    logic cmd_c;
    logic btn_o;
    logic btn_c;
    logic lim_o;
    logic lim_c;
    assign {lim_c, lim_o, btn_c, btn_o, cmd_c, cmd_o} = deb;

    // Configuration fields
    logic latching;
    logic two_wire;
    logic local_mode;
    logic adjustable;
    logic [6:0] dly_open;
    logic [6:0] dly_close;
    logic [6:0] boost_time;
    logic [7:0] thr;
    assign latching = ctrl[`CTRL_LATCH];
    assign two_wire = ctrl[`CTRL_TWO_WIRE] & ~latching;
    assign local_mode = ctrl[`CTRL_LOCAL];
    assign adjustable = ctrl[`CTRL_ADJUST];
    assign dly_open = lim_ticks(delay_cfg[6:0]);
    assign dly_close = lim_ticks(delay_cfg[14:8]);
    assign boost_time = lim_ticks(boost_cfg[30:24]);
    assign thr = adjustable ? trip_level : `TRIP_FIXED;

    // Command resolution; buttons ignore two-wire for manual positioning
    logic raw_o;
    logic raw_c;
    logic want_open;
    logic want_close;
    assign raw_o = local_mode ? btn_o : cmd_o;
    assign raw_c = local_mode ? btn_c
                 : (two_wire & ~local_mode) ? ~cmd_o : cmd_c;
    assign want_open = raw_o & ~raw_c;
    assign want_close = raw_c & ~raw_o;

    // Latching acts on trailing edges only
    logic prev_o;
    logic prev_c;
    logic go_open;
    logic go_close;
    assign go_open = prev_o & ~raw_o & ~raw_c;
    assign go_close = prev_c & ~raw_c & ~raw_o;

    // Trip latch and limit permission
    logic trip;
    logic trip_dir_open;
    logic can_open;
    logic can_close;
    assign can_open = lim_o & ~(trip & trip_dir_open);
    assign can_close = lim_c & ~(trip & ~trip_dir_open);

    state_t state;
    state_t next_state;
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic [6:0] boost_cnt;
    logic pwr_pending;
    pwrup_t pwr_sel;
    logic running;
    logic over;
    assign running = (state == ST_RUN_OPEN) || (state == ST_RUN_CLOSE);
    assign over = running && (motor_current > thr);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            ST_IDLE: begin
                if (latching) begin
                    if (go_open && can_open) begin
                        next_state = ST_WAIT_OPEN;
                        next_cnt = 7'h00;
                    end else if (go_close && can_close) begin
                        next_state = ST_WAIT_CLOSE;
                        next_cnt = 7'h00;
                    end
                end else if (want_open && can_open) begin
                    next_state = ST_WAIT_OPEN;
                    next_cnt = dly_open;
                end else if (want_close && can_close) begin
                    next_state = ST_WAIT_CLOSE;
                    next_cnt = dly_close;
                end
            end
            ST_WAIT_OPEN: begin
                if ((!latching && !want_open) || !can_open)
                    next_state = ST_IDLE;
                else if (cnt == 7'h00)
                    next_state = ST_RUN_OPEN;
                else if (tick)
                    next_cnt = cnt - 7'h01;
            end
            ST_WAIT_CLOSE: begin
                if ((!latching && !want_close) || !can_close)
                    next_state = ST_IDLE;
                else if (cnt == 7'h00)
                    next_state = ST_RUN_CLOSE;
                else if (tick)
                    next_cnt = cnt - 7'h01;
            end
            ST_RUN_OPEN: begin
                if (latching && go_close && can_close) begin
                    // Pass through a wait so the open drive drops first
                    next_state = ST_WAIT_CLOSE;
                    next_cnt = 7'h00;
                end else if (!can_open || over) begin
                    next_state = latching ? ST_IDLE : ST_HOLD;
                    next_cnt = `HOLD_TICKS;
                end else if (!latching && !want_open) begin
                    next_state = ST_HOLD;
                    next_cnt = `HOLD_TICKS;
                end
            end
            ST_RUN_CLOSE: begin
                if (latching && go_open && can_open) begin
                    next_state = ST_WAIT_OPEN;
                    next_cnt = 7'h00;
                end else if (!can_close || over) begin
                    next_state = latching ? ST_IDLE : ST_HOLD;
                    next_cnt = `HOLD_TICKS;
                end else if (!latching && !want_close) begin
                    next_state = ST_HOLD;
                    next_cnt = `HOLD_TICKS;
                end
            end
            ST_HOLD: begin
                if (cnt != 7'h00) begin
                    if (tick)
                        next_cnt = cnt - 7'h01;
                end else if (pwr_pending && latching &&
                             pwr_sel == PWR_OPEN && can_open) begin
                    next_state = ST_WAIT_OPEN;
                    next_cnt = 7'h00;
                end else if (pwr_pending && latching &&
                             pwr_sel == PWR_CLOSE && can_close) begin
                    next_state = ST_WAIT_CLOSE;
                    next_cnt = 7'h00;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt = 7'h00;
            end
        endcase
    end

    logic next_drive_o;
    logic next_drive_c;
    logic next_trip;
    logic clear_rev;
    logic [7:0] next_pct;
    assign next_drive_o = (next_state == ST_RUN_OPEN);
    assign next_drive_c = (next_state == ST_RUN_CLOSE);
    assign clear_rev = trip && ((next_drive_o && !trip_dir_open) ||
                                (next_drive_c && trip_dir_open));
    // A new overcurrent wins over any clear in the same cycle
    assign next_trip = over | (trip & ~clear_rev & rst_s2);

    logic boost_on;
    logic [7:0] lat_pct;
    assign boost_on = boost_cnt < boost_time;
    assign lat_pct = clamp_pct(next_drive_o ? boost_cfg[15:8]
                                            : boost_cfg[23:16]);
    always_comb begin
        next_pct = `PCT_BASE;
        if (next_drive_o || next_drive_c) begin
            if (latching) begin
                if (boost_on)
                    next_pct = lat_pct;
            end else if (next_drive_o == ctrl[`CTRL_BOOST_OPEN]) begin
                next_pct = clamp_pct(boost_cfg[7:0]);
            end
        end
    end

    // The first second after reset lets software load the settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_HOLD;
            cnt <= `HOLD_TICKS;
            pwr_pending <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            if (state == ST_HOLD && cnt == 7'h00)
                pwr_pending <= 1'b0;
        end
    end

    // Power-up option is caught while the power-up hold runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pwr_sel <= PWR_IDLE;
        else if (pwr_pending)
            pwr_sel <= pwrup_t'(powerup_select);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_o <= 1'b0;
            prev_c <= 1'b0;
            boost_cnt <= 7'h00;
            trip <= 1'b0;
            trip_dir_open <= 1'b0;
        end else begin
            prev_o <= raw_o;
            prev_c <= raw_c;
            if (!running)
                boost_cnt <= 7'h00;
            else if (tick && boost_cnt != 7'h7F)
                boost_cnt <= boost_cnt + 7'h01;
            trip <= next_trip;
            if (over)
                trip_dir_open <= (state == ST_RUN_OPEN);
        end
    end

    // Motor and indicator outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_open <= 1'b0;
            drive_close <= 1'b0;
            brake_on <= 1'b1;
            red_led <= 1'b0;
            green_led <= 1'b0;
            torque_pct <= `PCT_BASE;
            trip_led <= 1'b0;
            trip_alarm <= 1'b0;
        end else begin
            drive_open <= next_drive_o;
            drive_close <= next_drive_c;
            brake_on <= ~(next_drive_o | next_drive_c);
            red_led <= next_drive_o;
            green_led <= next_drive_c;
            torque_pct <= next_pct;
            trip_led <= next_trip & adjustable;
            trip_alarm <= next_trip & adjustable;
        end
    end

    // APB slave: zero wait states, error on unmapped offsets
    logic hit_ctrl;
    logic hit_delay;
    logic hit_boost;
    logic hit_trip;
    logic hit_status;
    logic hit;
    logic wr;
    logic [31:0] rd_mux;
    assign hit_ctrl = (paddr == `OFF_CTRL);
    assign hit_delay = (paddr == `OFF_DELAY);
    assign hit_boost = (paddr == `OFF_BOOST);
    assign hit_trip = (paddr == `OFF_TRIP);
    assign hit_status = (paddr == `OFF_STATUS);
    assign hit = hit_ctrl | hit_delay | hit_boost | hit_trip | hit_status;
    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign rd_mux = hit_ctrl ? {27'h0, ctrl}
                  : hit_delay ? {16'h0, delay_cfg}
                  : hit_boost ? {1'b0, boost_cfg}
                  : hit_trip ? {24'h0, trip_level}
                  : hit_status ? {16'h0, deb, trip_dir_open, trip,
                                  drive_close, drive_open, state}
                  : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `RST_CTRL;
            delay_cfg <= `RST_DELAY;
            boost_cfg <= `RST_BOOST;
            trip_level <= `RST_TRIP;
            prdata <= 32'h00000000;
        end else begin
            if (psel && !penable)
                prdata <= rd_mux;
            if (wr && hit_ctrl)
                ctrl <= pwdata[4:0];
            if (wr && hit_delay)
                delay_cfg <= {1'b0, pwdata[14:8], 1'b0, pwdata[6:0]};
            if (wr && hit_boost)
                boost_cfg <= pwdata[30:0];
            if (wr && hit_trip)
                trip_level <= pwdata[7:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_outputs_exclusive: assert property (
        !(drive_open && drive_close))
        else $error("both motor outputs on");
    a_brake_when_off: assert property (
        brake_on == !(drive_open || drive_close))
        else $error("brake does not match idle outputs");
    a_led_match: assert property (
        red_led == drive_open && green_led == drive_close)
        else $error("indicator does not follow output");
    a_holdoff_follows: assert property (
        !latching && $fell(drive_open || drive_close) |-> state == ST_HOLD)
        else $error("no hold-off after move");
    a_latch_no_level: assert property (
        latching && state == ST_IDLE && !go_open && !go_close
        |=> state == ST_IDLE)
        else $error("latching started without pulse end");
    a_latch_immediate: assert property (
        latching && state == ST_IDLE && go_open && can_open
        |=> ##1 drive_open)
        else $error("latching open did not start at once");
    a_delay_cancel: assert property (
        !latching && state == ST_WAIT_OPEN && !want_open
        |=> state == ST_IDLE ##1 !drive_open)
        else $error("cancelled delay still drove");
    a_limit_stop: assert property (
        state == ST_RUN_OPEN && !lim_o |=> !drive_open)
        else $error("open drive past limit");
    a_trip_stop: assert property (
        over |=> trip && !drive_open && !drive_close)
        else $error("overcurrent did not trip");
    // Only a wait state can start the reversal that clears a trip
    a_trip_sticky: assert property (
        trip && rst_s2 && state != ST_WAIT_OPEN && state != ST_WAIT_CLOSE
        |=> trip)
        else $error("trip cleared without cause");

    c_nl_open_move: cover property (
        !latching ##1 state == ST_WAIT_OPEN ##[1:5] drive_open);
    c_latch_reverse: cover property (
        latching && drive_open ##1 state == ST_WAIT_CLOSE ##1 drive_close);
    c_trip_then_clear: cover property (trip ##[1:50] !trip);

endmodule

// ---- dc_motor_model.sv ----
// Behavioural DC motor with normally closed end-of-travel limit switches
`timescale 1ns/1ns

module dc_motor_model #(
    parameter int POS_MAX = 2000,
    parameter int POS_INIT = 600
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Motor drive from the controller
    input wire logic drive_open,
    input wire logic drive_close,
    // Fault injection from the bench
    input wire logic overload,
    // Limit switches and current sense
    output logic open_limit_ok,
    output logic close_limit_ok,
    output logic [7:0] motor_current
);
    int pos;

    // Travel moves one step per clock while a single direction is driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos <= POS_INIT;
        end else if (drive_open && !drive_close && pos < POS_MAX) begin
            pos <= pos + 1;
        end else if (drive_close && !drive_open && pos > 0) begin
            pos <= pos - 1;
        end
    end

    // Switches break contact only at the ends of travel
    assign open_limit_ok = (pos < POS_MAX);
    assign close_limit_ok = (pos > 0);
    // A jammed valve draws far more than the running current
    assign motor_current = overload ? 8'hC8 :
        (drive_open | drive_close) ? 8'h28 : 8'h00;
endmodule

// ---- tb_dc_valve_actuator_controller.sv ----
// Self-checking bench for the valve actuator controller
`timescale 1ns/1ns
`include "dc_valve_regs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end

module tb_dc_valve_actuator_controller;
    import dc_valve_pkg::*;
    // Short tick keeps the 1 s hold and the delays used to under a hundred clocks
    localparam int TK = 8;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, err;
    logic open_cmd = 0, close_cmd = 0, open_button = 0, close_button = 0;
    logic trip_reset_n = 1, overload = 0;
    logic [1:0] powerup_select = 2'h0;
    logic open_limit_ok, close_limit_ok, drive_open, drive_close, brake_on;
    logic red_led, green_led, trip_led, trip_alarm;
    logic [7:0] motor_current, torque_pct;
    int n_mismatch = 0, checked = 0;

    always #10 pclk = ~pclk;

    dc_valve_actuator_controller #(.TICK_CYCLES(TK)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .open_cmd(open_cmd),
        .close_cmd(close_cmd), .open_button(open_button),
        .close_button(close_button), .open_limit_ok(open_limit_ok),
        .close_limit_ok(close_limit_ok), .motor_current(motor_current),
        .trip_reset_n(trip_reset_n), .powerup_select(powerup_select),
        .drive_open(drive_open), .drive_close(drive_close),
        .brake_on(brake_on), .torque_pct(torque_pct), .red_led(red_led),
        .green_led(green_led), .trip_led(trip_led), .trip_alarm(trip_alarm));

    dc_motor_model motor (
        .pclk(pclk), .presetn(presetn), .drive_open(drive_open),
        .drive_close(drive_close), .overload(overload),
        .open_limit_ok(open_limit_ok), .close_limit_ok(close_limit_ok),
        .motor_current(motor_current));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tk(input int n);
        repeat (n * TK) @(posedge pclk);
    endtask

    // Waits for a drive pattern; a bounded wait that runs out ends the run
    task automatic wait_drv(input logic o, input logic c, input int ticks);
        int n;
        n = 0;
        // Flop outputs read at the edge hold what the previous edge set
        while ({drive_open, drive_close} !== {o, c} && n < ticks * TK) begin
            @(posedge pclk);
            n++;
            `CHK(drive_open & drive_close, 1'b0)
        end
        `CHK({drive_open, drive_close}, {o, c})
        if ({drive_open, drive_close} !== {o, c}) end_of_test();
    endtask

    // Checks a drive pattern holds steady for a number of ticks
    task automatic stay(input logic o, input logic c, input int ticks);
        int bad;
        bad = 0;
        repeat (ticks * TK) begin
            @(posedge pclk);
            if ({drive_open, drive_close} !== {o, c}) bad++;
        end
        `CHK(bad, 0)
    endtask

    task automatic done(input string s);
        $display("Test %s finished", s);
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `OFF_CTRL, 0); `CHK(q, 32'(`RST_CTRL))
        apb(0, `OFF_DELAY, 0); `CHK(q, 32'(`RST_DELAY))
        apb(0, `OFF_BOOST, 0); `CHK(q, 32'(`RST_BOOST))
        apb(0, `OFF_TRIP, 0); `CHK(q, 32'(`RST_TRIP))
        apb(0, 8'h14, 0); `CHK(err, 1'b1)
        done("registers");
        stay(0, 0, 14);
        `CHK(brake_on, 1'b1)
        done("power-up");
        apb(1, `OFF_CTRL, 32'h08);
        apb(1, `OFF_DELAY, 32'h08);
        apb(1, `OFF_BOOST, 32'h00646496);
        open_cmd <= 1'b1;
        tk(4);
        open_cmd <= 1'b0;
        stay(0, 0, 16);
        open_cmd <= 1'b1;
        stay(0, 0, 6);
        wait_drv(1, 0, 8);
        `CHK({red_led, green_led, brake_on}, 3'b100)
        `CHK(torque_pct, 8'h96)
        open_cmd <= 1'b0;
        wait_drv(0, 0, 4);
        close_cmd <= 1'b1;
        stay(0, 0, 8);
        wait_drv(0, 1, 6);
        `CHK({red_led, green_led}, 2'b01)
        `CHK(torque_pct, 8'h64)
        open_cmd <= 1'b1;
        wait_drv(0, 0, 4);
        open_cmd <= 1'b0;
        close_cmd <= 1'b0;
        tk(14);
        done("non-latching");
        apb(1, `OFF_CTRL, 32'h02);
        wait_drv(0, 1, 6);
        open_cmd <= 1'b1;
        wait_drv(1, 0, 24);
        open_cmd <= 1'b0;
        apb(1, `OFF_CTRL, 32'h06);
        tk(14);
        stay(0, 0, 4);
        open_button <= 1'b1;
        wait_drv(1, 0, 12);
        open_button <= 1'b0;
        open_cmd <= 1'b0;
        wait_drv(0, 0, 4);
        done("wiring and local");
        apb(1, `OFF_CTRL, 32'h00);
        tk(14);
        close_cmd <= 1'b1;
        wait_drv(0, 1, 8);
        wait_drv(0, 0, 150);
        stay(0, 0, 14);
        close_cmd <= 1'b0;
        open_cmd <= 1'b1;
        wait_drv(1, 0, 20);
        done("limits");
        apb(1, `OFF_TRIP, 32'h30);
        apb(1, `OFF_CTRL, 32'h10);
        overload <= 1'b1;
        wait_drv(0, 0, 4);
        `CHK({trip_led, trip_alarm}, 2'b11)
        overload <= 1'b0;
        stay(0, 0, 14);
        trip_reset_n <= 1'b0;
        tk(4);
        trip_reset_n <= 1'b1;
        tk(1);
        `CHK(trip_led, 1'b0)
        open_cmd <= 1'b0;
        tk(14);
        // Second trip while opening, cleared by a commanded reversal
        open_cmd <= 1'b1;
        wait_drv(1, 0, 12);
        overload <= 1'b1;
        wait_drv(0, 0, 4);
        overload <= 1'b0;
        open_cmd <= 1'b0;
        close_cmd <= 1'b1;
        wait_drv(0, 1, 16);
        `CHK(trip_led, 1'b0)
        close_cmd <= 1'b0;
        tk(14);
        done("trip");
        apb(1, `OFF_BOOST, 32'h0564B464);
        apb(1, `OFF_CTRL, 32'h03);
        open_cmd <= 1'b1;
        stay(0, 0, 20);
        open_cmd <= 1'b0;
        wait_drv(1, 0, 4);
        `CHK(torque_pct, 8'hB4)
        tk(7);
        `CHK(torque_pct, 8'h64)
        close_cmd <= 1'b1;
        tk(3);
        close_cmd <= 1'b0;
        wait_drv(0, 1, 8);
        done("latching");
        // Mid-run reset with the close power-up option
        presetn <= 1'b0;
        powerup_select <= 2'h2;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1, `OFF_CTRL, 32'h01);
        wait_drv(0, 1, 14);
        done("power-up close");
        end_of_test();
    end
endmodule
